// file: rtl/dram_dma_pkg.sv
// Shared constants for the data RAM access and DMA port
package dram_dma_pkg;
  localparam int RAM_ADDR_W  = 24;
  localparam int XFER_ADDR_W = 26;
  localparam int WORD_W      = 32;
  localparam int LANES       = 4;
  localparam int SIZE_W      = 2;
  localparam int WORD_LSB    = 2;
  localparam logic [SIZE_W-1:0] SIZE_BYTE  = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_HALF  = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_WORD  = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_RSVD  = 2'h3;
  localparam logic              DIR_READ   = 1'b0;
  localparam logic              DIR_WRITE  = 1'b1;
  localparam logic [LANES-1:0]  BWE_NONE   = 4'h0;
  localparam logic [LANES-1:0]  BWE_ALL    = 4'hf;
  localparam logic [LANES-1:0]  BWE_BYTE0  = 4'h1;
  localparam logic [LANES-1:0]  BWE_HALF0  = 4'h3;
  localparam int BUF_DEPTH   = 2;
endpackage : dram_dma_pkg

// file: rtl/dram_dma_if.sv
// Link between the DMA controller end and the data RAM port end
`timescale 1ns/1ps
interface dram_dma_if;
  import dram_dma_pkg::*;
  logic [XFER_ADDR_W-1:0] xfer_byte_addr;
  logic [WORD_W-1:0]      xfer_write_word;
  logic                   xfer_port_en;
  logic [SIZE_W-1:0]      xfer_write_size;
  logic                   xfer_req_n;
  logic                   xfer_dir_sel;
  logic [WORD_W-1:0]      xfer_read_word;
  logic                   xfer_read_valid;
  logic                   xfer_read_ready;
  logic                   xfer_req_ready;
  logic                   xfer_core_stalled;
  logic                   xfer_stall_req;
  modport port_end (
    input  xfer_byte_addr, xfer_write_word, xfer_port_en, xfer_write_size, xfer_req_n,
           xfer_dir_sel, xfer_stall_req, xfer_read_ready,
    output xfer_read_word, xfer_read_valid, xfer_req_ready, xfer_core_stalled
  );
  modport dma_end (
    output xfer_byte_addr, xfer_write_word, xfer_port_en, xfer_write_size, xfer_req_n,
           xfer_dir_sel, xfer_stall_req, xfer_read_ready,
    input  xfer_read_word, xfer_read_valid, xfer_req_ready, xfer_core_stalled
  );
endinterface : dram_dma_if

// file: rtl/dma_requester.sv
// DMA controller end: issues byte-addressed transfers over the link
`timescale 1ns/1ps
module dma_requester
  import dram_dma_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  dram_dma_if.dma_end                 link,
  input  wire logic                   dual_port,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic                   cmd_write,
  input  wire logic [XFER_ADDR_W-1:0] cmd_addr,
  input  wire logic [SIZE_W-1:0]      cmd_size,
  input  wire logic [WORD_W-1:0]      cmd_wdata,
  output logic                        rsp_valid,
  output logic [WORD_W-1:0]           rsp_rdata
);
  typedef enum logic [2:0] {
    Q_IDLE  = 3'b001,
    Q_STALL = 3'b010,
    Q_REQ   = 3'b100
  } dstate_e;

  dstate_e              state_r;
  logic [XFER_ADDR_W-1:0] addr_r;
  logic [WORD_W-1:0]    wdata_r;
  logic [SIZE_W-1:0]    size_r;
  logic                 dir_r;
  logic                 stall_r;
  logic                 en_r;
  logic                 req_n_r;
  logic                 dual_s1_r;
  logic                 dual_r;

  // Strap pin passes two flops, in step with the port end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dual_s1_r <= 1'b0;
      dual_r    <= 1'b0;
    end else begin
      dual_s1_r <= dual_port;
      dual_r    <= dual_s1_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= Q_IDLE;
      addr_r  <= '0;
      wdata_r <= '0;
      size_r  <= SIZE_WORD;
      dir_r   <= DIR_READ;
      stall_r <= 1'b0;
      en_r    <= 1'b0;
      req_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        Q_IDLE: begin
          if (cmd_valid) begin
            addr_r  <= cmd_addr;  // [R6]
            wdata_r <= cmd_wdata; // [R7]
            size_r  <= (cmd_size == SIZE_RSVD) ? SIZE_WORD : cmd_size; // [R11]
            dir_r   <= cmd_write ? DIR_WRITE : DIR_READ; // [R21]
            en_r    <= 1'b1; // [R8]
            stall_r <= ~dual_r; // [R15] [R18]
            state_r <= dual_r ? Q_REQ : Q_STALL;
            req_n_r <= ~dual_r ? 1'b1 : 1'b0; // [R14]
          end else begin
            en_r    <= 1'b0; // [R9] [R10]
            stall_r <= 1'b0;
            req_n_r <= 1'b1;
          end
        end
        Q_STALL: begin
          if (link.xfer_core_stalled) begin // [R17]
            req_n_r <= 1'b0;
            state_r <= Q_REQ;
          end
        end
        Q_REQ: begin
          if (link.xfer_req_ready) begin
            req_n_r <= 1'b1;
            stall_r <= 1'b0;
            en_r    <= 1'b0;
            state_r <= Q_IDLE;
          end
        end
        default: state_r <= Q_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= link.xfer_read_valid;
      if (link.xfer_read_valid) begin
        rsp_rdata <= link.xfer_read_word;
      end
    end
  end

  assign cmd_ready              = (state_r == Q_IDLE);
  assign link.xfer_byte_addr    = addr_r;
  assign link.xfer_write_word   = wdata_r;
  assign link.xfer_write_size   = size_r;
  assign link.xfer_dir_sel      = dir_r;
  assign link.xfer_port_en      = en_r;
  assign link.xfer_req_n        = req_n_r;
  assign link.xfer_stall_req    = stall_r;
  assign link.xfer_read_ready   = 1'b1;
endmodule : dma_requester

// file: rtl/data_ram_dma_port.sv
// Data RAM port: core access, DMA sharing with stall, dual-port second port
// Summary of operation
// R1 - Four active-high byte write enables, bit3 top lane
// R2 - RAM addresses are 24-bit word addresses
// R3 - Dual-port DMA uses only the second port
// R4 - Chip enable high marks an active access
// R5 - Byte write enables high only for writes
// R6 - DMA gives 26-bit byte address, unused zero
// R7 - DMA supplies 32-bit write data
// R8 - DMA transfers only while port enable high
// R9 - DMA drops port enable when idle
// R10 - Port enable tied low when unused
// R11 - Size code byte, halfword, word; 11 reserved
// R12 - DMA reads always return full word
// R13 - Read data on dedicated 32-bit output
// R14 - Transfer requested by active-low request
// R15 - Single-port: raise wait before any transfer
// R16 - Ready high once core has stalled
// R17 - DMA samples ready high before transferring
// R18 - Wait only single-port; low for dual-port
// R19 - Single-port: core stalled, DMA shares signals
// R20 - Dual-port: core keeps running during DMA; code skips the core access in the S_RDATA cycle after each DMA read
// R21 - Direction low read, high write
// R22 - Sub-word writes enable only addressed lanes
`timescale 1ns/1ps
module data_ram_dma_port
  import dram_dma_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  dram_dma_if.port_end               link,
  input  wire logic                  dual_port,
  input  wire logic                  core_req,
  input  wire logic                  core_write,
  input  wire logic [RAM_ADDR_W-1:0] core_word_addr,
  input  wire logic [LANES-1:0]      core_lanes,
  input  wire logic [WORD_W-1:0]     core_wdata,
  output logic [WORD_W-1:0]          core_rdata,
  output logic                       core_hold,
  output logic [RAM_ADDR_W-1:0]      ram_word_addr,
  output logic                       ram_chip_en,
  output logic [WORD_W-1:0]          ram_write_word,
  output logic [LANES-1:0]           ram_byte_write_en,
  input  wire logic [WORD_W-1:0]     ram_read_word,
  output logic [RAM_ADDR_W-1:0]      port2_word_addr,
  output logic                       port2_chip_en,
  output logic [WORD_W-1:0]          port2_write_word,
  output logic [LANES-1:0]           port2_byte_write_en,
  input  wire logic [WORD_W-1:0]     port2_read_word
);
  typedef enum logic [2:0] {
    S_RUN   = 3'b001,
    S_HELD  = 3'b010,
    S_RDATA = 3'b100
  } pstate_e;

  // Lane mask from size and low address bits
  function automatic logic [LANES-1:0] lane_mask(input logic [SIZE_W-1:0] sz, input logic [1:0] lo);
    logic [LANES-1:0] m;
    m = BWE_ALL;
    unique case (sz)
      SIZE_BYTE: m = BWE_BYTE0 << lo;                  // [R22]
      SIZE_HALF: m = BWE_HALF0 << {lo[1], 1'b0};       // [R22]
      default:   m = BWE_ALL;                          // [R11]
    endcase
    return m;
  endfunction : lane_mask

  pstate_e            state_r;
  logic               stall_s1_r;
  logic               stall_s2_r;
  logic               act_s1_r;
  logic               act_r;
  logic               dual_s1_r;
  logic               dual_r;
  logic               on_p2_r;
  logic               rd_pend_r;
  logic               push;
  logic               pop;
  logic [WORD_W-1:0]  buf_word_r [BUF_DEPTH];
  logic [0:0]         buf_wp_r;
  logic [0:0]         buf_rp_r;
  logic [1:0]         buf_cnt_r;
  logic               dma_go;
  logic               dma_wr;
  logic               buf_in_rdy;
  logic [WORD_W-1:0]  rd_word;

  // Link pins come from another block; synchronise the level controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stall_s1_r <= 1'b0;
      stall_s2_r <= 1'b0;
      act_s1_r   <= 1'b0;
      act_r      <= 1'b0;
      dual_s1_r  <= 1'b0;
      dual_r     <= 1'b0;
    end else begin
      stall_s1_r <= link.xfer_stall_req;
      stall_s2_r <= stall_s1_r;
      act_s1_r   <= link.xfer_port_en & ~link.xfer_req_n;
      act_r      <= act_s1_r;
      // Strap pin passes two flops before use
      dual_s1_r  <= dual_port;
      dual_r     <= dual_s1_r;
    end
  end

  assign buf_in_rdy = ((buf_cnt_r + 2'(rd_pend_r)) < 2'(BUF_DEPTH));
  // A read may only start when the return buffer has room, so no word drops
  // Ready still high means this request was just taken; never take it twice
  assign dma_go = act_r & link.xfer_port_en & ~link.xfer_req_n & (state_r != S_RDATA)  // [R8] [R14]
                & (dual_r | (state_r == S_HELD)) & (dma_wr | buf_in_rdy) & ~link.xfer_req_ready;
  assign dma_wr = (link.xfer_dir_sel == DIR_WRITE); // [R21]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_RUN;
    end else begin
      unique case (state_r)
        S_RUN:   if (!dual_r && stall_s2_r) state_r <= S_HELD; // [R19]
        S_HELD: begin
          if (!stall_s2_r) state_r <= S_RUN;
          else if (dma_go && !dma_wr) state_r <= S_RDATA;
        end
        S_RDATA: state_r <= (dual_r || !stall_s2_r) ? S_RUN : S_HELD;
        default: state_r <= S_RUN;
      endcase
      if (dual_r && dma_go && !dma_wr && state_r == S_RUN) state_r <= S_RDATA;
    end
  end

  // Registered RAM drive: DMA owns port 1 while held, else port 2 when dual
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ram_word_addr       <= '0;
      ram_chip_en         <= 1'b0;
      ram_write_word      <= '0;
      ram_byte_write_en   <= BWE_NONE;
      port2_word_addr     <= '0;
      port2_chip_en       <= 1'b0;
      port2_write_word    <= '0;
      port2_byte_write_en <= BWE_NONE;
      on_p2_r             <= 1'b0;
      core_hold           <= 1'b0;
    end else begin
      core_hold <= ~dual_r & (stall_s2_r | state_r != S_RUN); // [R19] [R20]
      ram_chip_en         <= 1'b0;
      ram_byte_write_en   <= BWE_NONE;
      port2_chip_en       <= 1'b0;
      port2_byte_write_en <= BWE_NONE;
      if (dma_go && dual_r) begin
        port2_word_addr     <= link.xfer_byte_addr[WORD_LSB +: RAM_ADDR_W]; // [R2] [R3]
        port2_chip_en       <= 1'b1; // [R4]
        port2_write_word    <= link.xfer_write_word;
        port2_byte_write_en <= dma_wr ? lane_mask(link.xfer_write_size, link.xfer_byte_addr[1:0]) : BWE_NONE; // [R5]
        on_p2_r             <= 1'b1;
      end
      if (dma_go && !dual_r) begin
        ram_word_addr     <= link.xfer_byte_addr[WORD_LSB +: RAM_ADDR_W]; // [R2] [R19]
        ram_chip_en       <= 1'b1; // [R4]
        ram_write_word    <= link.xfer_write_word;
        ram_byte_write_en <= dma_wr ? lane_mask(link.xfer_write_size, link.xfer_byte_addr[1:0]) : BWE_NONE; // [R1] [R5]
        on_p2_r           <= 1'b0;
      end else if (core_req && state_r == S_RUN && !(stall_s2_r && !dual_r)) begin
        ram_word_addr     <= core_word_addr; // [R2]
        ram_chip_en       <= 1'b1; // [R4]
        ram_write_word    <= core_wdata;
        ram_byte_write_en <= core_write ? core_lanes : BWE_NONE; // [R1] [R5] [R20]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_rdata <= '0;
    end else begin
      core_rdata <= ram_read_word;
    end
  end

  // Full word captured regardless of the size code
  assign rd_word = on_p2_r ? port2_read_word : ram_read_word; // [R12]

  // RAM answers one cycle after the chip enable edge, so the push waits a cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= (state_r == S_RDATA);
    end
  end

  assign push = rd_pend_r;
  // Pop only when the word is offered, so a second stored word is never skipped
  assign pop  = (buf_cnt_r != 2'h0) & link.xfer_read_ready & ~link.xfer_read_valid;

  // Two-entry return buffer between the RAM and the DMA read-data output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_wp_r   <= '0;
      buf_rp_r   <= '0;
      buf_cnt_r  <= '0;
      buf_word_r[0] <= '0;
      buf_word_r[1] <= '0;
    end else begin
      if (push) begin
        buf_word_r[buf_wp_r] <= rd_word;
        buf_wp_r <= buf_wp_r + 1'b1;
      end
      if (pop) buf_rp_r <= buf_rp_r + 1'b1;
      buf_cnt_r  <= buf_cnt_r + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.xfer_read_word    <= '0;
      link.xfer_read_valid   <= 1'b0;
      link.xfer_req_ready    <= 1'b0;
      link.xfer_core_stalled <= 1'b0;
    end else begin
      link.xfer_read_valid   <= pop;
      link.xfer_read_word    <= buf_word_r[buf_rp_r]; // [R13]
      link.xfer_req_ready    <= dma_go;
      link.xfer_core_stalled <= ~dual_r & stall_s2_r & (state_r != S_RUN); // [R16]
    end
  end
endmodule : data_ram_dma_port

// file: testbench/dma_link_properties.sv
// Concurrent checks on the link between the DMA requester and the RAM port
`timescale 1ns/1ps
module dma_link_properties
  import dram_dma_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [XFER_ADDR_W-1:0] xfer_byte_addr,
  input wire logic                   xfer_port_en,
  input wire logic [SIZE_W-1:0]      xfer_write_size,
  input wire logic                   xfer_req_n,
  input wire logic                   xfer_dir_sel,
  input wire logic                   xfer_read_valid,
  input wire logic                   xfer_req_ready,
  input wire logic                   xfer_core_stalled,
  input wire logic                   xfer_stall_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_size_not_rsvd: assert property (xfer_write_size != SIZE_RSVD)
    else $error("reserved size code on link");
  a_taken_needs_en: assert property (xfer_req_ready |-> $past(xfer_port_en) && !$past(xfer_req_n))
    else $error("request taken without enable");
  a_req_has_en: assert property (!xfer_req_n |-> xfer_port_en)
    else $error("request while port disabled");
  a_stall_after_wait: assert property ($rose(xfer_core_stalled) |-> $past(xfer_stall_req, 2))
    else $error("stalled flag without wait request");
  a_wait_first: assert property ($rose(xfer_stall_req) |-> xfer_req_n [*2])
    else $error("request issued together with wait");
  a_stalled_at_take: assert property (xfer_req_ready && xfer_stall_req |-> xfer_core_stalled)
    else $error("transfer taken before core stalled");
  a_req_holds: assert property (!xfer_req_n && !xfer_req_ready |=>
      $stable(xfer_byte_addr) && $stable(xfer_dir_sel) && $stable(xfer_write_size))
    else $error("request changed before taken");
  a_taken_in_time: assert property ($fell(xfer_req_n) |-> ##[1:16] xfer_req_ready)
    else $error("request not taken in time");
  a_read_one_cycle: assert property (xfer_read_valid |=> !xfer_read_valid)
    else $error("read valid longer than one cycle");
endmodule : dma_link_properties

// file: testbench/test_data_ram_dma_port.sv
// Requester and RAM port joined, with a shared dual-port RAM model
`timescale 1ns/1ps
module test_data_ram_dma_port;
  import dram_dma_pkg::*;
  logic clk = 0, rst = 1, dp = 0, cv = 0, cw = 0, cr = 0, rv, creq = 0, hold, cwr = 0;
  logic [3:0]  cln = '0;
  logic [31:0] cwd = '0;
  logic [25:0] ca = '0;
  logic [1:0]  cs = SIZE_WORD;
  logic [31:0] cd = '0, rd, crd, r1, r2, w1, w2, mem [0:15];
  logic [23:0] a1, a2, p1a, p2a, cwa = '0;
  logic [3:0]  e1, e2, p1we, p2we;
  logic        c1, c2, s_hold, s_p1;
  int          error_cnt = 0, check_count = 0;
  dram_dma_if dram_dma_if_inst ();
  dma_requester dma_requester_inst (.clk(clk), .rst(rst), .link(dram_dma_if_inst.dma_end), .dual_port(dp),
    .cmd_valid(cv), .cmd_ready(cr), .cmd_write(cw), .cmd_addr(ca), .cmd_size(cs), .cmd_wdata(cd),
    .rsp_valid(rv), .rsp_rdata(rd));
  data_ram_dma_port data_ram_dma_port_inst (.clk(clk), .rst(rst), .link(dram_dma_if_inst.port_end),
    .dual_port(dp), .core_req(creq), .core_write(cwr), .core_word_addr(cwa), .core_lanes(cln),
    .core_wdata(cwd), .core_rdata(crd), .core_hold(hold), .ram_word_addr(a1), .ram_chip_en(c1),
    .ram_write_word(w1), .ram_byte_write_en(e1), .ram_read_word(r1), .port2_word_addr(a2),
    .port2_chip_en(c2), .port2_write_word(w2), .port2_byte_write_en(e2), .port2_read_word(r2));
  dma_link_properties dma_link_properties_inst (.clk(clk), .rst(rst),
    .xfer_byte_addr(dram_dma_if_inst.xfer_byte_addr), .xfer_port_en(dram_dma_if_inst.xfer_port_en),
    .xfer_write_size(dram_dma_if_inst.xfer_write_size), .xfer_req_n(dram_dma_if_inst.xfer_req_n),
    .xfer_dir_sel(dram_dma_if_inst.xfer_dir_sel), .xfer_read_valid(dram_dma_if_inst.xfer_read_valid),
    .xfer_req_ready(dram_dma_if_inst.xfer_req_ready), .xfer_core_stalled(dram_dma_if_inst.xfer_core_stalled),
    .xfer_stall_req(dram_dma_if_inst.xfer_stall_req));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] we);
    for (int b = 0; b < 4; b++) if (we[b]) o[b*8+:8] = d[b*8+:8];
    return o;
  endfunction : merge
  // Both ports reach one array, as a real dual-port RAM would; read data lands one cycle later
  always @(posedge clk) begin
    if (hold === 1'b1) s_hold <= 1'b1;
    if (c1 === 1'b1) begin
      s_p1 <= 1'b1;
      mem[a1[3:0]] <= merge(mem[a1[3:0]], w1, e1);
      r1 <= mem[a1[3:0]];
      if (e1 !== 4'h0) begin p1we <= e1; p1a <= a1; end
    end else r1 <= ~r1;
    if (c2 === 1'b1) begin
      mem[a2[3:0]] <= merge(mem[a2[3:0]], w2, e2);
      r2 <= mem[a2[3:0]];
      if (e2 !== 4'h0) begin p2we <= e2; p2a <= a2; end
    end else r2 <= ~r2;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic xfer(input logic w, input logic [25:0] a, input logic [1:0] s, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cv <= 1'b1; cw <= w; ca <= a; cs <= s; cd <= d;
    do begin @(posedge clk); n++; end while (cr !== 1'b1 && n < 50);
    cv <= 1'b0;
    while ((w ? dram_dma_if_inst.xfer_req_ready : rv) !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    q = rd;
    if (n >= 100) chk("transfer done", 1, 0);
    repeat (2) @(posedge clk);
  endtask : xfer
  task automatic t_single_lanes;
    logic [31:0] q;
    dp <= 1'b0; s_hold = 1'b0;
    xfer(1'b1, 26'h000_0014, SIZE_WORD, 32'h0000_0000, q);
    chk("word lanes", 4'hf, p1we);
    chk("word addr", 24'h00_0005, p1a);
    chk("core held", 1, s_hold);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 26'h000_0014 + 26'(i), SIZE_BYTE, {4{8'(8'h11 * (i + 1))}}, q);
      chk("byte lanes", 4'h1 << i, p1we);
    end
    xfer(1'b1, 26'h000_0016, SIZE_HALF, 32'h7777_7777, q);
    chk("half lanes", 4'hc, p1we);
    p1we = 4'h0;
    xfer(1'b0, 26'h000_0014, SIZE_BYTE, 32'h0000_0000, q);
    chk("full word read", 32'h7777_2211, q);
    chk("no write on read", 4'h0, p1we);
    xfer(1'b1, 26'h3ff_fffc, SIZE_WORD, 32'h1234_5678, q);
    chk("top word addr", 24'hff_ffff, p1a);
  endtask : t_single_lanes
  task automatic t_dual_port;
    logic [31:0] q;
    dp <= 1'b1;
    // Both ends see the strap only after their two flops and the last stall ends
    repeat (6) @(posedge clk);
    s_hold = 1'b0; s_p1 = 1'b0;
    xfer(1'b1, 26'h000_0020, SIZE_WORD, 32'hcafe_f00d, q);
    chk("port2 lanes", 4'hf, p2we);
    chk("port2 addr", 24'h00_0008, p2a);
    chk("port1 idle", 0, s_p1);
    xfer(1'b0, 26'h000_0020, SIZE_HALF, 32'h0000_0000, q);
    chk("port2 read", 32'hcafe_f00d, q);
    chk("core free", 0, s_hold);
    cwa <= 24'h00_0008; creq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("core read", 32'hcafe_f00d, crd);
    cwa <= 24'h00_0009; cwr <= 1'b1; cln <= 4'hf; cwd <= 32'hdead_beef;
    @(posedge clk);
    cwr <= 1'b0; cln <= 4'h0;
    repeat (4) @(posedge clk);
    chk("core write lanes", 4'hf, p1we);
    chk("core write back", 32'hdead_beef, crd);
    creq <= 1'b0;
  endtask : t_dual_port
  initial begin
    #(5 * 4000);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    r1 = '0; r2 = '0; p1we = '0; p2we = '0; p1a = '0; p2a = '0; s_hold = 0; s_p1 = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_single_lanes;
    t_dual_port;
    report_and_stop;
  end
endmodule : test_data_ram_dma_port
